/* File: hw/gfbf_pkg.sv */
package gfbf_pkg;

   // ----------------------------------------------------------------
   // command and status carriers
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {GFBF_RAW, GFBF_HEAD_SYNC, GFBF_HEAD_DATA, GFBF_BLOCK} gfbf_kind_type;

   typedef struct packed {
      logic rx;
      gfbf_kind_type kind;
      logic [1:0] size;
      logic crc_en;
   } gfbf_cmd_type;

   typedef struct packed {
      logic done;
      logic crc_checked;
      logic crc_ok;
      logic fec_fixed;
      logic fec_bad;
   } gfbf_stat_type;

   // ----------------------------------------------------------------
   // default code values (sync word arbitrary, overridable)
   // ----------------------------------------------------------------
   localparam logic [15:0] GFBF_SYNC_WORD = 16'haaaa;
   localparam logic [15:0] GFBF_FRAME_SYNC = 16'h3b28;
   localparam logic [15:0] GFBF_CRC_POLY = 16'h1021;
   localparam logic [15:0] GFBF_CRC_INIT = 16'hffff;
   localparam logic [31:0] GFBF_HAM_MASK = 32'hf08e6d5b;

   // ----------------------------------------------------------------
   // block sizes and counts
   // ----------------------------------------------------------------
   localparam logic [4:0] GFBF_HEAD_SYNC_USER = 5'h02;
   localparam logic [4:0] GFBF_HEAD_DATA_USER = 5'h06;
   localparam logic [4:0] GFBF_CRC_BYTES = 5'h02;
   localparam logic [19:0] GFBF_BLOCK_USER = {5'h12, 5'h0c, 5'h06, 5'h04};
   localparam logic [1:0] GFBF_SYNC_LAST = 2'h3;
   localparam logic [5:0] GFBF_HEAD_SYNC_AIR = 6'h07;
   localparam logic [5:0] GFBF_HEAD_DATA_AIR = 6'h07;
   localparam logic [4:0] GFBF_MAX_DATA = 5'h14;

   // user byte count of a command
   function automatic logic [4:0] gfbf_user(input gfbf_cmd_type c);
      logic [4:0] n;
      case (c.kind)
         GFBF_HEAD_SYNC: n = GFBF_HEAD_SYNC_USER;
         GFBF_HEAD_DATA: n = GFBF_HEAD_DATA_USER;
         default: n = GFBF_BLOCK_USER[5'h05 * {3'h0, c.size} +: 5];
      endcase
      return n;
   endfunction

   // four check bits of one byte, one parity mask per bit
   function automatic logic [3:0] gfbf_chk(input logic [7:0] b, input logic [31:0] m);
      logic [3:0] c;
      for (int k = 0; k < 4; k++)
      begin
         c[k] = ^(b & m[8*k +: 8]);
      end
      return c;
   endfunction

   // single error correction: {fixed, uncorrectable, byte}
   function automatic logic [9:0] gfbf_fix(input logic [7:0] b, input logic [3:0] c,
                                           input logic [31:0] m);
      logic [3:0] syn;
      logic [7:0] o;
      logic e;
      syn = gfbf_chk(b, m) ^ c;
      o = b;
      e = (syn != 4'h0) && ($countones(syn) != 1);
      for (int j = 0; j < 8; j++)
      begin
         if (syn == {m[24+j], m[16+j], m[8+j], m[j]})
         begin
            o[j] = ~o[j];
            e = 1'b0;
         end
      end
      return {syn != 4'h0, e, o};
   endfunction

endpackage

/* File: hw/gfbf_crc16.sv */
module gfbf_crc16 #(
   parameter logic [15:0] POLY = gfbf_pkg::GFBF_CRC_POLY,
   parameter logic [15:0] INIT = gfbf_pkg::GFBF_CRC_INIT
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clear,
   input wire logic en,
   input wire logic [7:0] data,
   output logic [15:0] crc
);
   import gfbf_pkg::*;

   logic [15:0] next_crc;
   logic [15:0] c;

   // msb-first byte update
   always_comb
   begin
      c = crc;
      next_crc = crc;
      if (clear)
      begin
         next_crc = INIT;
      end
      else if (en)
      begin
         for (int i = 7; i >= 0; i--)
         begin
            if (c[15] ^ data[i])
            begin
               c = {c[14:0], 1'b0} ^ POLY;
            end
            else
            begin
               c = {c[14:0], 1'b0};
            end
         end
         next_crc = c;
      end
   end

   // register
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         crc <= INIT;
      end
      else
      begin
         crc <= next_crc;
      end
   end

endmodule

/* File: hw/gfbf_framer.sv */
// Notes on behaviour
// - Transmit head with sync starts with 16-bit sync word, then 16-bit frame sync.
// - Block does all coding itself; host sees only payload bytes.
// - Received CRC blocks report pass or fail; data always delivered.
// - Data blocks hold 4, 6, 12 or 18 user bytes, optional 2-byte CRC.
// - Head with sync carries 2 user bytes plus 1 check byte.
// - User-data head carries 6 user bytes plus 1 check byte.
// - Blocks without CRC add 2, 3, 6 or 9 check bytes.
// - Blocks with CRC add 3, 4, 7 or 10 check bytes.
// - Hamming-type correction protects blocks; CRC detects errors.
// - Raw transfers pass bytes with no coding or CRC.
// - Optional CRC is 16 bits over the block's user bytes.
module gfbf_framer #(
   parameter logic [15:0] SYNC_WORD = gfbf_pkg::GFBF_SYNC_WORD,
   parameter logic [15:0] FRAME_SYNC = gfbf_pkg::GFBF_FRAME_SYNC,
   parameter logic [15:0] CRC_POLY = gfbf_pkg::GFBF_CRC_POLY,
   parameter logic [15:0] CRC_INIT = gfbf_pkg::GFBF_CRC_INIT,
   parameter logic [31:0] HAM_MASK = gfbf_pkg::GFBF_HAM_MASK
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire gfbf_pkg::gfbf_cmd_type cmd,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic [7:0] air_tx_byte,
   output logic air_tx_valid,
   input wire logic air_tx_ready,
   input wire logic [7:0] air_rx_byte,
   input wire logic air_rx_valid,
   output logic air_rx_ready,
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   output gfbf_pkg::gfbf_stat_type stat_out
);
   import gfbf_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {ST_IDLE, ST_SYNC, ST_DATA, ST_FEC, ST_DLV, ST_END} gfbf_state_type;

   gfbf_state_type state, next_state;
   gfbf_cmd_type cur, next_cur;
   gfbf_stat_type stat, next_stat;
   logic [4:0] idx, next_idx;
   logic [1:0] sidx, next_sidx;
   logic [7:0] obyte, next_obyte;
   logic ovalid, next_ovalid;
   logic [7:0] acc, next_acc;
   logic [7:0] fold, next_fold;
   logic [7:0] pb0, next_pb0;
   logic [7:0] pb1, next_pb1;
   logic dsel, next_dsel;
   logic [7:0] rdata, next_rdata;
   logic rvalid, next_rvalid;
   logic [15:0] rcrc, next_rcrc;
   logic fixed, next_fixed;
   logic bad, next_bad;
   logic crc_clr, crc_en;
   logic [7:0] crc_din;
   logic [15:0] crc_val;
   logic [4:0] n_user, n_data, pos;
   logic last, user_ph, tx_slot, tx_go, rx_slot;
   logic [7:0] tx_b, db, pair;
   logic [31:0] sync_all;
   logic [9:0] fx0, fx1;
   logic [5:0] air_cnt;
   logic [4:0] rx_cnt;

   // ----------------------------------------------------------------
   // shared decode
   // ----------------------------------------------------------------
   assign n_user = gfbf_user(cur);
   assign n_data = cur.crc_en && cur.kind == GFBF_BLOCK ? n_user + GFBF_CRC_BYTES : n_user;
   assign last = idx == n_data - 5'h01;
   assign user_ph = idx < n_user;
   assign pos = {idx[4:1], dsel};
   assign sync_all = {SYNC_WORD, FRAME_SYNC};
   assign db = dsel ? pb1 : pb0;
   assign tx_slot = !ovalid || air_tx_ready;
   assign rx_slot = !rvalid || rx_ready;
   assign tx_go = state == ST_DATA && !cur.rx && tx_slot && (!user_ph || tx_valid);
   assign tx_b = user_ph ? tx_data : (idx[0] ? crc_val[7:0] : crc_val[15:8]);
   assign pair = {gfbf_chk(cur.rx ? pb0 : acc, HAM_MASK)
                  & {4{cur.rx}} | acc[7:4] & {4{!cur.rx}},
                  gfbf_chk(cur.rx ? air_rx_byte : tx_b, HAM_MASK)};

   // handshakes
   assign cmd_ready = state == ST_IDLE;
   assign tx_ready = state == ST_DATA && !cur.rx && tx_slot && user_ph;
   assign air_rx_ready = cur.rx && (state == ST_DATA || state == ST_FEC);
   assign air_tx_byte = obyte;
   assign air_tx_valid = ovalid;
   assign rx_data = rdata;
   assign rx_valid = rvalid;
   assign stat_out = stat;

   // crc over user bytes only
   gfbf_crc16 #(
      .POLY(CRC_POLY),
      .INIT(CRC_INIT)
   ) u_crc (
      .ref_clk(ref_clk),
      .rst(rst),
      .clear(crc_clr),
      .en(crc_en),
      .data(crc_din),
      .crc(crc_val)
   );

   // ----------------------------------------------------------------
   // framing sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      next_cur = cur;
      next_idx = idx;
      next_sidx = sidx;
      next_obyte = obyte;
      next_ovalid = ovalid && !air_tx_ready;
      next_acc = acc;
      next_fold = fold;
      next_pb0 = pb0;
      next_pb1 = pb1;
      next_dsel = dsel;
      next_rdata = rdata;
      next_rvalid = rvalid && !rx_ready;
      next_rcrc = rcrc;
      next_fixed = fixed;
      next_bad = bad;
      next_stat = stat;
      next_stat.done = 1'b0;
      crc_clr = 1'b0;
      crc_en = 1'b0;
      crc_din = tx_b;
      fx0 = gfbf_fix(pb0, air_rx_byte[7:4], HAM_MASK);
      fx1 = gfbf_fix(pb1, air_rx_byte[3:0], HAM_MASK);
      case (state)
         ST_IDLE:
         begin
            if (cmd_valid)
            begin
               next_cur = cmd;
               next_idx = 5'h00;
               next_sidx = 2'h0;
               next_fold = 8'h00;
               next_dsel = 1'b0;
               next_fixed = 1'b0;
               next_bad = 1'b0;
               crc_clr = 1'b1;
               next_state = !cmd.rx && cmd.kind == GFBF_HEAD_SYNC ? ST_SYNC : ST_DATA;
            end
         end
         ST_SYNC:
         begin
            // sync word then frame sync, high byte first
            if (tx_slot)
            begin
               next_obyte = sync_all[{~sidx, 3'h0} +: 8];
               next_ovalid = 1'b1;
               next_sidx = sidx + 2'h1;
               if (sidx == GFBF_SYNC_LAST)
               begin
                  next_state = ST_DATA;
               end
            end
         end
         ST_DATA:
         begin
            if (tx_go)
            begin
               next_obyte = tx_b;
               next_ovalid = 1'b1;
               crc_en = user_ph && cur.kind != GFBF_RAW;
               if (!idx[0])
               begin
                  next_acc = {pair[3:0], 4'h0};
                  next_idx = idx + 5'h01;
               end
               else if (cur.kind == GFBF_RAW)
               begin
                  next_state = last ? ST_END : ST_DATA;
                  next_idx = last ? idx : idx + 5'h01;
               end
               else if (cur.kind == GFBF_HEAD_DATA)
               begin
                  next_fold = fold ^ pair;
                  next_acc = fold ^ pair;
                  next_state = last ? ST_FEC : ST_DATA;
                  next_idx = last ? idx : idx + 5'h01;
               end
               else
               begin
                  next_acc = pair;
                  next_state = ST_FEC;
               end
            end
            else if (cur.rx && air_rx_valid)
            begin
               if (!idx[0])
               begin
                  next_pb0 = air_rx_byte;
                  next_idx = idx + 5'h01;
               end
               else
               begin
                  next_pb1 = air_rx_byte;
                  next_fold = fold ^ pair;
                  next_state = cur.kind == GFBF_RAW || cur.kind == GFBF_HEAD_DATA ? ST_DLV : ST_FEC;
               end
            end
         end
         ST_FEC:
         begin
            if (!cur.rx && tx_slot)
            begin
               next_obyte = acc;
               next_ovalid = 1'b1;
               next_state = last ? ST_END : ST_DATA;
               next_idx = last ? idx : idx + 5'h01;
            end
            else if (cur.rx && air_rx_valid && cur.kind == GFBF_HEAD_DATA)
            begin
               next_bad = bad | (air_rx_byte != fold);
               next_state = ST_END;
            end
            else if (cur.rx && air_rx_valid)
            begin
               next_pb0 = fx0[7:0];
               next_pb1 = fx1[7:0];
               next_fixed = fixed | fx0[9] | fx1[9];
               next_bad = bad | fx0[8] | fx1[8];
               next_state = ST_DLV;
            end
         end
         ST_DLV:
         begin
            // user bytes to host (corrected for blocks and sync heads only), received crc bytes kept
            crc_din = db;
            if (pos >= n_user || rx_slot)
            begin
               if (pos < n_user)
               begin
                  next_rdata = db;
                  next_rvalid = 1'b1;
                  crc_en = cur.kind != GFBF_RAW;
               end
               else if (pos[0])
               begin
                  next_rcrc[7:0] = db;
               end
               else
               begin
                  next_rcrc[15:8] = db;
               end
               next_dsel = !dsel;
               if (dsel)
               begin
                  next_state = !last ? ST_DATA : (cur.kind == GFBF_HEAD_DATA ? ST_FEC : ST_END);
                  next_idx = last ? idx : idx + 5'h01;
               end
            end
         end
         ST_END:
         begin
            // report once the last byte has left
            if (!ovalid && !rvalid)
            begin
               next_stat.done = 1'b1;
               next_stat.crc_checked = cur.rx && n_data != n_user;
               next_stat.crc_ok = cur.rx && n_data != n_user && rcrc == crc_val;
               next_stat.fec_fixed = fixed;
               next_stat.fec_bad = bad;
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // register
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         state <= ST_IDLE;
         cur <= '0;
         stat <= '0;
         idx <= 5'h00;
         sidx <= 2'h0;
         obyte <= 8'h00;
         ovalid <= 1'b0;
         acc <= 8'h00;
         fold <= 8'h00;
         pb0 <= 8'h00;
         pb1 <= 8'h00;
         dsel <= 1'b0;
         rdata <= 8'h00;
         rvalid <= 1'b0;
         rcrc <= 16'h0000;
         fixed <= 1'b0;
         bad <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cur <= next_cur;
         stat <= next_stat;
         idx <= next_idx;
         sidx <= next_sidx;
         obyte <= next_obyte;
         ovalid <= next_ovalid;
         acc <= next_acc;
         fold <= next_fold;
         pb0 <= next_pb0;
         pb1 <= next_pb1;
         dsel <= next_dsel;
         rdata <= next_rdata;
         rvalid <= next_rvalid;
         rcrc <= next_rcrc;
         fixed <= next_fixed;
         bad <= next_bad;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // byte counters seen only by the checks
   always_ff @(posedge ref_clk)
   begin
      if (rst || (cmd_valid && cmd_ready))
      begin
         air_cnt <= 6'h00;
         rx_cnt <= 5'h00;
      end
      else
      begin
         air_cnt <= air_cnt + {5'h00, air_tx_valid && air_tx_ready};
         rx_cnt <= rx_cnt + {4'h0, rx_valid && rx_ready};
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   sequence s_head_start;
      cmd_valid && cmd_ready && !cmd.rx && cmd.kind == GFBF_HEAD_SYNC;
   endsequence
   sequence s_sync_first;
      air_tx_valid && air_tx_byte == SYNC_WORD[15:8];
   endsequence

   sync_first_a: assert property (s_head_start |-> ##2 s_sync_first)
      else $error("sync word not first on air");
   rx_user_cnt_a: assert property ((state == ST_END && cur.rx && !rvalid)
      |-> rx_cnt == n_user)
      else $error("host got wrong byte count");
   crc_report_a: assert property ((state == ST_END && cur.rx && n_data != n_user && !rvalid)
      |=> stat.done && stat.crc_checked && stat.crc_ok == (rcrc == crc_val))
      else $error("crc result not reported");
   idx_range_a: assert property (state != ST_IDLE |-> idx < GFBF_MAX_DATA)
      else $error("byte index past block");
   head_sync_len_a: assert property ((state == ST_END && !cur.rx && !ovalid
      && cur.kind == GFBF_HEAD_SYNC) |-> air_cnt == GFBF_HEAD_SYNC_AIR)
      else $error("sync head length wrong");
   head_data_len_a: assert property ((state == ST_END && !cur.rx && !ovalid
      && cur.kind == GFBF_HEAD_DATA) |-> air_cnt == GFBF_HEAD_DATA_AIR)
      else $error("data head length wrong");
   blk_plain_len_a: assert property ((state == ST_END && !cur.rx && !ovalid
      && cur.kind == GFBF_BLOCK && !cur.crc_en)
      |-> air_cnt == {1'b0, n_user} + {2'h0, n_user[4:1]})
      else $error("plain block length wrong");
   blk_crc_len_a: assert property ((state == ST_END && !cur.rx && !ovalid
      && cur.kind == GFBF_BLOCK && cur.crc_en)
      |-> air_cnt == {1'b0, n_user} + 6'h03 + {2'h0, n_user[4:1]})
      else $error("crc block length wrong");
   fec_pair_a: assert property ((state == ST_FEC && !cur.rx && cur.kind == GFBF_BLOCK)
      |-> idx[0] && air_tx_valid)
      else $error("check byte not after pair");
   raw_plain_a: assert property ((cur.kind == GFBF_RAW && state != ST_IDLE)
      |-> state != ST_FEC && !crc_en)
      else $error("raw transfer got coding");
   crc_high_a: assert property ((tx_go && cur.crc_en && cur.kind == GFBF_BLOCK && idx == n_user)
      |=> air_tx_byte == $past(crc_val[15:8]))
      else $error("crc high byte wrong");

endmodule

/* File: test/gfbf_modem_model.sv */
module gfbf_modem_model (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic slow,
   input wire logic [7:0] air_tx_byte,
   input wire logic air_tx_valid,
   output logic air_tx_ready,
   output logic [7:0] air_rx_byte,
   output logic air_rx_valid,
   input wire logic air_rx_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] txq[$];
   logic [7:0] rxq[$];
   logic tick;
   logic rtake;

   initial
   begin
      air_tx_ready = 1'b0;
      air_rx_byte = 8'h00;
      air_rx_valid = 1'b0;
      tick = 1'b0;
      rtake = 1'b0;
   end

   // collect coded bytes and note receive hand-offs
   always @(posedge ref_clk)
   begin
      if (air_tx_valid && air_tx_ready)
      begin
         txq.push_back(air_tx_byte);
      end
      rtake = air_rx_valid && air_rx_ready;
   end

   // pace both directions, stalling on alternate cycles when slow
   always @(negedge ref_clk)
   begin
      tick = ~tick;
      air_tx_ready = !rst && (!slow || tick);
      if (rtake)
      begin
         rxq.delete(0);
         air_rx_valid = 1'b0;
         air_rx_byte = ~air_rx_byte; // released line shows no stale byte
         rtake = 1'b0;
      end
      if (!air_rx_valid && rxq.size() > 0 && (!slow || tick))
      begin
         air_rx_valid = 1'b1;
         air_rx_byte = rxq[0];
      end
   end
endmodule

/* File: test/gfbf_framer_test.sv */
module gfbf_framer_test;
   timeunit 1ns;
   timeprecision 1ps;
   import gfbf_pkg::*;
   typedef logic [7:0] gfbf_byte_q_type[$];
   localparam logic [15:0] T_SYNC = 16'h5a5a;
   localparam logic [15:0] T_FS = 16'h1dc3;
   localparam logic [15:0] T_POLY = 16'h8005;
   localparam logic [15:0] T_INIT = 16'h0000;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   gfbf_cmd_type cmd = '0;
   logic cmd_valid = 1'b0;
   logic cmd_ready, tx_ready, air_tx_valid, air_tx_ready, air_rx_valid, air_rx_ready;
   logic rx_valid;
   logic [7:0] tx_data = 8'h00;
   logic tx_valid = 1'b0;
   logic rx_ready = 1'b0;
   logic slow = 1'b0;
   logic [7:0] air_tx_byte, air_rx_byte, rx_data;
   gfbf_stat_type stat_out;
   logic [31:0] seed = 32'd96763;
   int n_fail = 0;
   int checks_done = 0;

   gfbf_framer #(.SYNC_WORD(T_SYNC), .FRAME_SYNC(T_FS), .CRC_POLY(T_POLY), .CRC_INIT(T_INIT),
      .HAM_MASK(GFBF_HAM_MASK)) i_dut (.ref_clk(ref_clk), .rst(rst), .cmd(cmd),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .air_tx_byte(air_tx_byte), .air_tx_valid(air_tx_valid),
      .air_tx_ready(air_tx_ready), .air_rx_byte(air_rx_byte), .air_rx_valid(air_rx_valid),
      .air_rx_ready(air_rx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .stat_out(stat_out));

   gfbf_modem_model i_modem (.ref_clk(ref_clk), .rst(rst), .slow(slow),
      .air_tx_byte(air_tx_byte), .air_tx_valid(air_tx_valid), .air_tx_ready(air_tx_ready),
      .air_rx_byte(air_rx_byte), .air_rx_valid(air_rx_valid), .air_rx_ready(air_rx_ready));

   // clock
   initial
   begin
      forever #20 ref_clk = ~ref_clk;
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xorshift();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [3:0] chk(input logic [7:0] b);
      logic [3:0] c;
      for (int k = 0; k < 4; k++)
      begin
         c[k] = ^(b & GFBF_HAM_MASK[8*k +: 8]);
      end
      return c;
   endfunction

   // msb-first crc over user bytes
   function automatic logic [15:0] crc_of(input gfbf_byte_q_type u);
      logic [15:0] c;
      logic fb;
      c = T_INIT;
      foreach (u[i])
      begin
         for (int b = 7; b >= 0; b--)
         begin
            fb = c[15] ^ u[i][b];
            c = {c[14:0], 1'b0} ^ (fb ? T_POLY : 16'h0000);
         end
      end
      return c;
   endfunction

   // expected air bytes after the sync fields
   function automatic gfbf_byte_q_type encode(input gfbf_kind_type k, input logic ce,
                                              input logic bad, input gfbf_byte_q_type u);
      gfbf_byte_q_type a, d;
      logic [15:0] c;
      logic [7:0] f, x;
      a = {};
      d = u;
      x = 8'h00;
      if (k == GFBF_RAW)
      begin
         return u;
      end
      if (k == GFBF_BLOCK && ce)
      begin
         c = crc_of(u) ^ {15'h0000, bad};
         d.push_back(c[15:8]);
         d.push_back(c[7:0]);
      end
      for (int i = 0; i < d.size(); i += 2)
      begin
         f = {chk(d[i]), chk(d[i+1])};
         x ^= f;
         a.push_back(d[i]);
         a.push_back(d[i+1]);
         if (k != GFBF_HEAD_DATA)
         begin
            a.push_back(f);
         end
      end
      if (k == GFBF_HEAD_DATA)
      begin
         a.push_back(x);
      end
      return a;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // one transfer: err 0 clean, 1 flipped user bit, 2 wrong crc
   task automatic run(input logic rx, input gfbf_kind_type k, input logic [1:0] sz,
                      input logic ce, input int err);
      gfbf_byte_q_type u, a, e, got;
      gfbf_cmd_type c;
      gfbf_stat_type s, es;
      logic [31:0] r;
      logic [7:0] rb;
      logic tp, rp;
      int n, nt, ti;
      n = (k == GFBF_HEAD_SYNC) ? 2 : (k == GFBF_HEAD_DATA) ? 6 : sz == 0 ? 4 :
          sz == 1 ? 6 : sz == 2 ? 12 : 18;
      for (int i = 0; i < n; i++)
      begin
         r = xorshift();
         u.push_back(r[7:0]);
      end
      a = encode(k, ce, err == 2, u);
      if (err == 1)
         a[0] ^= 8'h10;
      c = '{rx, k, sz, ce};
      nt = rx ? 0 : n;
      ti = 0;
      tp = 1'b0;
      rp = 1'b0;
      s = '0;
      @(negedge ref_clk);
      slow = r[9];
      if (rx)
         i_modem.rxq = a;
      cmd = c;
      cmd_valid = 1'b1;
      // offer stays up while busy and must be ignored
      for (int cyc = 0; cyc < 3000 && !s.done; cyc++)
      begin
         @(negedge ref_clk);
         #2;
         r = xorshift();
         if (tp)
            ti++;
         if (rp)
            got.push_back(rb);
         s = stat_out;
         cmd_valid = !s.done;
         if (!tx_valid || tp)
         begin
            tx_valid = ti < nt && r[0];
            tx_data = ti < nt ? u[ti] : ~tx_data;
         end
         rx_ready = r[1];
         tp = tx_valid && tx_ready;
         rp = rx_valid && rx_ready;
         rb = rx_data;
      end
      if (!rx)
      begin
         if (k == GFBF_HEAD_SYNC)
            e = {T_SYNC[15:8], T_SYNC[7:0], T_FS[15:8], T_FS[7:0]};
         e = {e, a};
         check(s, 5'h10);
         check(i_modem.txq.size(), e.size());
         foreach (e[i])
            check(i_modem.txq[i], e[i]);
         i_modem.txq = {};
      end
      else
      begin
         es = '{1'b1, k == GFBF_BLOCK && ce, k == GFBF_BLOCK && ce && err != 2,
                err == 1 && k != GFBF_HEAD_DATA, err == 1 && k == GFBF_HEAD_DATA};
         // user-data head only detects, so the hit byte arrives as sent
         if (err == 1 && k == GFBF_HEAD_DATA)
            u[0] ^= 8'h10;
         check(s, es);
         check(i_modem.rxq.size(), 0);
         check(got.size(), n);
         foreach (u[i])
            check(got[i], u[i]);
      end
      $display("test rx=%0d kind=%0d size=%0d crc=%0d err=%0d ended", rx, k, sz, ce, err);
   endtask

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial
   begin
      repeat (6) @(negedge ref_clk);
      rst = 1'b0;
      for (int d = 0; d < 2; d++)
      begin
         for (int s = 0; s < 4; s++)
            run(d[0], GFBF_RAW, 2'(s), 1'b0, 0);
         run(d[0], GFBF_HEAD_SYNC, 2'h0, 1'b0, 0);
         run(d[0], GFBF_HEAD_DATA, 2'h0, 1'b0, 0);
         for (int s = 0; s < 8; s++)
            run(d[0], GFBF_BLOCK, 2'(s), s[2], 0);
      end
      run(1'b1, GFBF_BLOCK, 2'h3, 1'b1, 1);
      run(1'b1, GFBF_BLOCK, 2'h0, 1'b0, 1);
      run(1'b1, GFBF_BLOCK, 2'h1, 1'b1, 2);
      run(1'b1, GFBF_HEAD_SYNC, 2'h0, 1'b0, 1);
      run(1'b1, GFBF_HEAD_DATA, 2'h0, 1'b0, 1);
      give_verdict();
   end

   initial
   begin
      repeat (40000) @(posedge ref_clk);
      n_fail++;
      give_verdict();
   end
endmodule
